// [src/pmc_top.sv]
// power management control register, phy reset and wake event logic
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module pmc_top #(
  parameter int     PHY_RESET_REQUEST_CYCLES = pmc_pkg::PMC_PHY_RESET_REQUEST_CYCLES,
  parameter longint PULSE_CYCLES   = pmc_pkg::PMC_PULSE_CYCLES,
  parameter int     SETTLE_CYCLES  = pmc_pkg::PMC_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // wake event sources
  input  wire logic        wake_frame_event,
  input  wire logic        energy_detect_event,
  // phy reset
  output logic             phy_reset_out,
  // power event outputs
  output logic             power_event_interrupt,
  output logic             power_event_out_o,
  output logic             power_event_out_oe,
  output logic             power_event_active,
  // status
  output logic      [1:0]  power_state_out,
  output logic             device_ready
);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMC_SETTLE = 3'b001,
    PMC_RUN    = 3'b010,
    PMC_SLEEP  = 3'b100
  } pmc_fsm_t;

  pmc_fsm_t         fsm_reg;
  pmc_fsm_t         fsm_next;
  logic [1:0]       state_sel_reg;
  logic             wake_frame_event_enable_reg;
  logic             energy_detect_event_enable_reg;
  logic             buf_type_reg;
  logic             pulse_mode_reg;
  logic             polarity_reg;
  logic             out_en_reg;
  logic [1:0]       wake_status_reg;
  logic             phy_reset_request_reg;
  logic             read_seen_reg;
  logic [31:0]      rdata_reg;
  logic [15:0]      settle_cnt_reg;
  logic             int_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire        ready_w     = (fsm_reg == PMC_RUN);
  wire        sel_ctrl_w  = (reg_addr == pmc_pkg::PMC_ADDR_CONTROL);
  wire        sel_test_w  = (reg_addr == pmc_pkg::PMC_ADDR_BYTE_TEST);
  // control writes count only once ready and after a read has been seen
  wire        wr_ok_w     = reg_wr && ready_w && read_seen_reg;
  wire        wr_ctrl_w   = wr_ok_w && sel_ctrl_w;
  wire        wake_req_w  = (fsm_reg == PMC_SLEEP) && reg_wr && sel_test_w;
  wire        phy_busy_w;
  wire        phy_done_w;
  wire        phy_start_w = wr_ctrl_w && reg_wdata[pmc_pkg::PMC_BIT_PHY_RESET_REQUEST]
                            && !phy_reset_request_reg;
  wire [1:0]  new_state_w = reg_wdata[pmc_pkg::PMC_BIT_STATE_LO +: 2];
  wire        go_sleep_w  = wr_ctrl_w && ((new_state_w == pmc_pkg::PMC_STATE_WAKE) ||
                            (new_state_w == pmc_pkg::PMC_STATE_ENERGY));

  // ----------------------------------------
  // wake event qualification
  // ----------------------------------------
  wire        ev_frame_w  = wake_frame_event_enable_reg && wake_frame_event;
  wire        ev_energy_w = energy_detect_event_enable_reg && energy_detect_event;
  wire [1:0]  ev_vec_w    = {ev_frame_w, ev_energy_w};
  wire [1:0]  clr_w       = (wr_ctrl_w && ready_w)
                            ? reg_wdata[pmc_pkg::PMC_BIT_WAKE_LO +: 2] : 2'h0;
  // set wins over clear; an active source whose enable is set keeps its bit set
  wire [1:0]  status_next = (wake_status_reg & ~clr_w) | ev_vec_w;
  wire        new_ev_w    = |(ev_vec_w & ~wake_status_reg);
  wire        en_match_w  = (wake_status_reg[1] && wake_frame_event_enable_reg) ||
                            (wake_status_reg[0] && energy_detect_event_enable_reg);

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always_comb begin
    fsm_next = fsm_reg;
    case (fsm_reg)
      PMC_SETTLE: begin
        if (settle_cnt_reg == 16'(SETTLE_CYCLES - 1)) begin
          fsm_next = PMC_RUN;
        end
      end
      PMC_RUN: begin
        if (go_sleep_w) begin
          fsm_next = PMC_SLEEP;
        end
      end
      PMC_SLEEP: begin
        if (wake_req_w) begin
          fsm_next = PMC_SETTLE;
        end
      end
      default: begin
        fsm_next = PMC_SETTLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fsm_reg        <= PMC_SETTLE;
      settle_cnt_reg <= 16'h0000;
    end else begin
      fsm_reg        <= fsm_next;
      settle_cnt_reg <= (fsm_reg == PMC_SETTLE) ? settle_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_sel_reg  <= pmc_pkg::PMC_STATE_NORMAL;
      wake_frame_event_enable_reg     <= 1'b0;
      energy_detect_event_enable_reg      <= 1'b0;
      buf_type_reg   <= 1'b0;
      pulse_mode_reg <= 1'b0;
      polarity_reg   <= 1'b0;
      out_en_reg     <= 1'b0;
    end else begin
      if (go_sleep_w) begin
        state_sel_reg <= new_state_w;
      end else if (wake_req_w) begin
        state_sel_reg <= pmc_pkg::PMC_STATE_NORMAL;
      end
      if (wr_ctrl_w) begin
        wake_frame_event_enable_reg     <= reg_wdata[pmc_pkg::PMC_BIT_WAKE_FRAME_EVENT_ENABLE];
        energy_detect_event_enable_reg      <= reg_wdata[pmc_pkg::PMC_BIT_ENERGY_DETECT_EVENT_ENABLE];
        buf_type_reg   <= reg_wdata[pmc_pkg::PMC_BIT_BUF_TYPE];
        pulse_mode_reg <= reg_wdata[pmc_pkg::PMC_BIT_PULSE];
        polarity_reg   <= reg_wdata[pmc_pkg::PMC_BIT_POL];
        out_en_reg     <= reg_wdata[pmc_pkg::PMC_BIT_OUT_EN];
      end
    end
  end

  // ----------------------------------------
  // read tracking and read data
  // ----------------------------------------
  // a read of any address arms writes; a wake, or a settle cycle other than the last without a read, disarms them again
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      read_seen_reg <= 1'b0;
    end else if (fsm_reg != PMC_RUN) begin
      read_seen_reg <= reg_rd && (fsm_reg == PMC_SETTLE) ? 1'b1 :
                       (fsm_next == PMC_SETTLE) ? 1'b0 : read_seen_reg;
    end else if (reg_rd) begin
      read_seen_reg <= 1'b1;
    end
  end

  wire [31:0] ctrl_view_w = {18'h00000,
                             state_sel_reg, 1'b0, phy_reset_request_reg,
                             wake_frame_event_enable_reg, energy_detect_event_enable_reg, 1'b0, buf_type_reg,
                             wake_status_reg, pulse_mode_reg, polarity_reg,
                             out_en_reg, ready_w};

  // control register answers in every state; others read as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_reg <= sel_ctrl_w ? ctrl_view_w : 32'h00000000;
    end
  end

  // ----------------------------------------
  // wake status and interrupt
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wake_status_reg <= 2'h0;
      int_reg         <= 1'b0;
    end else begin
      wake_status_reg <= status_next;
      int_reg         <= |(status_next & {wake_frame_event_enable_reg, energy_detect_event_enable_reg});
    end
  end

  // ----------------------------------------
  // phy reset
  // ----------------------------------------
  pmc_timer #(.WIDTH(16)) u_phy_timer (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .start    (phy_start_w),
    .load_val (16'(PHY_RESET_REQUEST_CYCLES - 1)),
    .busy     (phy_busy_w),
    .done     (phy_done_w)
  );

  // bit drops only once the reset has been held its full length
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phy_reset_request_reg <= 1'b0;
    end else if (phy_start_w) begin
      phy_reset_request_reg <= 1'b1;
    end else if (phy_done_w) begin
      phy_reset_request_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // power event pin
  // ----------------------------------------
  pmc_pkg::pmc_cfg_t cfg_w;
  pmc_pkg::pmc_pin_t pin_w;

  assign cfg_w = '{wake_frame_event_enable:        wake_frame_event_enable_reg,
                   energy_detect_event_enable:         energy_detect_event_enable_reg,
                   buf_push_pull: buf_type_reg,
                   pulse_mode:    pulse_mode_reg,
                   polarity:      polarity_reg,
                   out_en:        out_en_reg};

  pmc_event_pin #(.PULSE_WIDTH(29)) u_pin (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .cfg           (cfg_w),
    .wake_pulse    (new_ev_w),
    .status_active (en_match_w),
    .pulse_cycles  (29'(PULSE_CYCLES - 1)),
    .pin           (pin_w)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata             = rdata_reg;
  assign phy_reset_out         = phy_reset_request_reg || phy_busy_w;
  assign power_event_interrupt = int_reg;
  assign power_event_out_o     = pin_w.drive;
  assign power_event_out_oe    = pin_w.oe;
  assign power_event_active    = pin_w.event_active;
  assign power_state_out       = state_sel_reg;
  assign device_ready          = ready_w;

endmodule

// [src/pmc_pkg.sv]
// constants, register layout and carrier types for the power management control block
package pmc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] PMC_ADDR_BYTE_TEST = 8'h64;
  localparam logic [7:0] PMC_ADDR_CONTROL   = 8'h84;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PMC_BIT_READY    = 0;
  localparam int PMC_BIT_OUT_EN   = 1;
  localparam int PMC_BIT_POL      = 2;
  localparam int PMC_BIT_PULSE    = 3;
  localparam int PMC_BIT_WAKE_LO  = 4;
  localparam int PMC_BIT_BUF_TYPE = 6;
  localparam int PMC_BIT_ENERGY_DETECT_EVENT_ENABLE    = 8;
  localparam int PMC_BIT_WAKE_FRAME_EVENT_ENABLE   = 9;
  localparam int PMC_BIT_PHY_RESET_REQUEST  = 10;
  localparam int PMC_BIT_STATE_LO = 12;

  // ----------------------------------------
  // encodings and reset values
  // ----------------------------------------
  localparam logic [1:0] PMC_STATE_NORMAL = 2'h0;
  localparam logic [1:0] PMC_STATE_WAKE   = 2'h1;
  localparam logic [1:0] PMC_STATE_ENERGY = 2'h2;
  localparam logic [1:0] PMC_WAKE_ENERGY  = 2'h1;
  localparam logic [1:0] PMC_WAKE_FRAME   = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int PMC_CLK_PERIOD_PS = 8000;
  localparam int PMC_PHY_RESET_REQUEST_US    = 100;
  localparam int PMC_PULSE_MS      = 50;
  localparam int PMC_SETTLE_CYCLES = 64;
  // least time rounds up
  localparam int PMC_PHY_RESET_REQUEST_CYCLES =
    (PMC_PHY_RESET_REQUEST_US * 1000000 + PMC_CLK_PERIOD_PS - 1) / PMC_CLK_PERIOD_PS;
  localparam longint PMC_PULSE_CYCLES =
    (64'(PMC_PULSE_MS) * 64'd1000000000) / 64'(PMC_CLK_PERIOD_PS);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       wake_frame_event_enable;
    logic       energy_detect_event_enable;
    logic       buf_push_pull;
    logic       pulse_mode;
    logic       polarity;
    logic       out_en;
  } pmc_cfg_t;

  typedef struct packed {
    logic       event_active;
    logic       drive;
    logic       oe;
  } pmc_pin_t;

endpackage

// [src/pmc_timer.sv]
// one-shot down counter: load, count, done pulse
`timescale 1ns/10ps
module pmc_timer #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load_val,
  // status
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] count_reg;
  logic             busy_reg;
  logic             done_reg;
  wire              last_w = busy_reg && (count_reg == '0);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= last_w;
      if (start) begin
        count_reg <= load_val;
        busy_reg  <= 1'b1;
      end else if (last_w) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

// [src/pmc_event_pin.sv]
// power event pin driver: pulse or level, polarity, open-drain or push-pull
`timescale 1ns/10ps
module pmc_event_pin #(
  parameter int PULSE_WIDTH = 29
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // control
  input  wire pmc_pkg::pmc_cfg_t      cfg,
  input  wire logic                   wake_pulse,
  input  wire logic                   status_active,
  input  wire logic [PULSE_WIDTH-1:0] pulse_cycles,
  // pin
  output pmc_pkg::pmc_pin_t           pin
);

  logic pulse_busy;
  logic active_w;
  logic drive_reg;
  logic oe_reg;
  logic act_reg;

  pmc_timer #(.WIDTH(PULSE_WIDTH)) u_pulse (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .start    (wake_pulse && cfg.pulse_mode),
    .load_val (pulse_cycles),
    .busy     (pulse_busy),
    .done     ()
  );

  // pulse mode still ends early if status or enable is dropped
  assign active_w = cfg.out_en && status_active &&
                    (cfg.pulse_mode ? pulse_busy : 1'b1);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drive_reg <= 1'b1;
      oe_reg    <= 1'b0;
      act_reg   <= 1'b0;
    end else begin
      act_reg <= active_w;
      if (cfg.buf_push_pull) begin
        drive_reg <= cfg.polarity ? active_w : !active_w;
        oe_reg    <= 1'b1;
      end else begin
        drive_reg <= 1'b0;
        oe_reg    <= active_w;
      end
    end
  end

  assign pin.event_active = act_reg;
  assign pin.drive        = drive_reg;
  assign pin.oe           = oe_reg;

endmodule

// [verif/pmc_properties.sv]
// concurrent checks on the power management control ports
`timescale 1ns/10ps
module pmc_properties #(
  parameter int     PHY_RESET_REQUEST_CYCLES = 20,
  parameter longint PULSE_CYCLES   = 50,
  parameter int     SETTLE_CYCLES  = 8
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // events and outputs
  input wire logic        wake_frame_event,
  input wire logic        energy_detect_event,
  input wire logic        phy_reset_out,
  input wire logic        power_event_interrupt,
  input wire logic        power_event_out_o,
  input wire logic        power_event_out_oe,
  input wire logic        power_event_active,
  input wire logic [1:0]  power_state_out,
  input wire logic        device_ready
);
  // counters for lengths too long to unroll
  logic [15:0] phy_cnt;
  logic [15:0] rdy_cnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phy_cnt <= 16'h0;
      rdy_cnt <= 16'h0;
    end else begin
      phy_cnt <= phy_reset_out ? phy_cnt + 16'h1 : 16'h0;
      rdy_cnt <= (!device_ready && power_state_out == 2'h0) ? rdy_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_PHY_HOLD: assert property (
    $fell(phy_reset_out) |-> phy_cnt >= PHY_RESET_REQUEST_CYCLES) else $error("phy reset too short");
  AST_INT_CAUSE: assert property (
    $rose(power_event_interrupt) |-> $past(wake_frame_event, 2) || $past(energy_detect_event, 2)
      || $past(wake_frame_event) || $past(energy_detect_event) || $past(reg_wr))
    else $error("interrupt without event");
  AST_PIN_AFTER_INT: assert property (
    $rose(power_event_active) |-> power_event_interrupt || $past(power_event_interrupt))
    else $error("pin active without interrupt");
  AST_ACTIVE_OE: assert property (
    power_event_active |-> power_event_out_oe) else $error("active pin not driven");
  AST_WAKE: assert property (
    reg_wr && reg_addr == 8'h64 && power_state_out != 2'h0
      |=> power_state_out == 2'h0 && !device_ready) else $error("byte test write did not wake");
  AST_SETTLE: assert property (
    $rose(device_ready) |-> rdy_cnt >= SETTLE_CYCLES - 1) else $error("ready too early");
  AST_NO_RESERVED: assert property (
    power_state_out != 2'h3) else $error("reserved power state");
  AST_LOW_NOT_READY: assert property (
    power_state_out != 2'h0 |-> !device_ready) else $error("ready in reduced power");
  AST_RD_READY: assert property (
    reg_rd && reg_addr == 8'h84 |=> reg_rdata[0] == $past(device_ready)
      && reg_rdata[13:12] == $past(power_state_out)) else $error("control read mismatch");
endmodule

// [verif/pmc_host_model.sv]
// host bus model: one-cycle register reads and writes
`timescale 1ns/10ps
module pmc_host_model (
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // callers never write state 11, poll ready, touch only 0x64 and 0x84 while not ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // a read arms later writes
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// [verif/test_power_management_control.sv]
// self-checking bench for the power management control block
`timescale 1ns/10ps
module test_power_management_control;
  localparam int         PHY_N = 20;
  localparam logic [7:0] CTRL  = pmc_pkg::PMC_ADDR_CONTROL;
  localparam logic [7:0] BTST  = pmc_pkg::PMC_ADDR_BYTE_TEST;
  logic        ref_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        wake_frame_event;
  logic        energy_detect_event;
  logic        phy_reset_out;
  logic        power_event_interrupt;
  logic        power_event_out_o;
  logic        power_event_out_oe;
  logic        power_event_active;
  logic [1:0]  power_state_out;
  logic        device_ready;
  logic [31:0] rd_val;
  int          errors;
  int          total_checks;
  int          cycles;
  int          phy_hi;
  pmc_top #(.PHY_RESET_REQUEST_CYCLES(PHY_N), .PULSE_CYCLES(50), .SETTLE_CYCLES(8)) u_pmc_top (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_frame_event(wake_frame_event), .energy_detect_event(energy_detect_event),
    .phy_reset_out(phy_reset_out), .power_event_interrupt(power_event_interrupt),
    .power_event_out_o(power_event_out_o), .power_event_out_oe(power_event_out_oe),
    .power_event_active(power_event_active), .power_state_out(power_state_out),
    .device_ready(device_ready));
  pmc_host_model u_host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // hang guard and phy reset length
  always @(posedge ref_clk) begin
    cycles++;
    if (phy_reset_out === 1'b1) phy_hi++;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask
  // interrupt, pin drive, enable, active
  task automatic pins(input logic [3:0] exp);
    #1 chk({28'h0, power_event_interrupt, power_event_out_o, power_event_out_oe,
            power_event_active}, {28'h0, exp});
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 100 && device_ready !== 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, device_ready}, 32'h1);
  endtask
  task automatic t_arm;
    chk({31'h0, device_ready}, 32'h0);
    wait_ready();
    u_host.wr(CTRL, 32'h0000_0002);
    rd_chk(CTRL, 32'h0000_0001);
    rd_chk(8'h88, 32'h0);
    u_host.wr(CTRL, 32'h0000_0002);
    rd_chk(CTRL, 32'h0000_0003);
  endtask
  task automatic t_phy;
    u_host.wr(CTRL, 32'h0000_0402);
    rd_chk(CTRL, 32'h0000_0403);
    u_host.wr(CTRL, 32'h0000_0002);
    rd_chk(CTRL, 32'h0000_0403);
    for (int i = 0; i < 200 && phy_reset_out === 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, phy_hi >= PHY_N}, 32'h1);
    rd_chk(CTRL, 32'h0000_0003);
  endtask
  // push-pull active high, level mode
  task automatic t_frame;
    u_host.wr(CTRL, 32'h0000_0246);
    @(posedge ref_clk) wake_frame_event <= 1'b1;
    @(posedge ref_clk) wake_frame_event <= 1'b0;
    repeat (3) @(posedge ref_clk);
    pins(4'b1111);
    rd_chk(CTRL, 32'h0000_0267);
    repeat (80) @(posedge ref_clk);
    pins(4'b1111);
    u_host.wr(CTRL, 32'h0000_0266);
    repeat (3) @(posedge ref_clk);
    pins(4'b0010);
    rd_chk(CTRL, 32'h0000_0247);
  endtask
  // open-drain ignores polarity, pulse mode, source held during clear
  task automatic t_energy;
    u_host.wr(CTRL, 32'h0000_010E);
    @(posedge ref_clk) energy_detect_event <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pins(4'b1011);
    u_host.wr(CTRL, 32'h0000_011E);
    rd_chk(CTRL, 32'h0000_011F);
    repeat (30) @(posedge ref_clk);
    pins(4'b1011);
    repeat (30) @(posedge ref_clk);
    #1 chk({29'h0, power_event_interrupt, power_event_out_oe, power_event_active}, 32'h4);
    u_host.wr(CTRL, 32'h0000_000E);
    // the interrupt register sees the cleared enable one edge after the write lands
    @(posedge ref_clk);
    #1 chk({31'h0, power_event_interrupt}, 32'h0);
    @(posedge ref_clk) energy_detect_event <= 1'b0;
    u_host.wr(CTRL, 32'h0000_0312);
    rd_chk(CTRL, 32'h0000_0303);
    @(posedge ref_clk) wake_frame_event <= 1'b1;
    energy_detect_event <= 1'b1;
    @(posedge ref_clk) wake_frame_event <= 1'b0;
    energy_detect_event <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_chk(CTRL, 32'h0000_0333);
    u_host.wr(CTRL, 32'h0000_0332);
    rd_chk(CTRL, 32'h0000_0303);
  endtask
  task automatic t_sleep;
    u_host.wr(CTRL, 32'h0000_1002);
    rd_chk(CTRL, 32'h0000_1002);
    u_host.wr(BTST, 32'h0);
    wait_ready();
    rd_chk(CTRL, 32'h0000_0003);
    u_host.wr(CTRL, 32'h0000_2002);
    rd_chk(CTRL, 32'h0000_2002);
    u_host.wr(BTST, 32'h0);
    wait_ready();
    u_host.wr(CTRL, 32'h0);
    rd_chk(CTRL, 32'h0000_0003);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    wake_frame_event = 1'b0;
    energy_detect_event = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    phy_hi = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_arm();
    t_phy();
    t_frame();
    t_energy();
    t_sleep();
    wrap_up();
  end
endmodule
bind pmc_top pmc_properties #(.PHY_RESET_REQUEST_CYCLES(PHY_RESET_REQUEST_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)) u_pmc_properties (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_frame_event(wake_frame_event), .energy_detect_event(energy_detect_event),
  .phy_reset_out(phy_reset_out), .power_event_interrupt(power_event_interrupt),
  .power_event_out_o(power_event_out_o), .power_event_out_oe(power_event_out_oe),
  .power_event_active(power_event_active), .power_state_out(power_state_out),
  .device_ready(device_ready));
